// ### design/uls_fifo.sv
// Synchronous FIFO with push and pop in the same cycle
`timescale 1ns/1ns
`default_nettype none
module uls_fifo #(parameter int W = 8, parameter int DEPTH = 8) (
	input wire logic clk,
	input wire logic rst,
	uls_fifo_if.fifo f
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
	localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
	logic [W-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wp_ff;
	logic [AW-1:0] rp_ff;
	logic [CW-1:0] cnt_ff;
	logic push;
	logic pop;

	assign f.wr_ready = cnt_ff != CNT_FULL;
	assign f.rd_valid = cnt_ff != '0;
	assign f.rd_data = mem_ff[rp_ff];
	assign f.count = cnt_ff;
	assign push = f.wr_valid & f.wr_ready;
	assign pop = f.rd_valid & f.rd_ready;

	always_ff @(posedge clk)
	begin
		if (push)
		begin
			mem_ff[wp_ff] <= f.wr_data;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wp_ff <= '0;
			rp_ff <= '0;
			cnt_ff <= '0;
		end
		else
		begin
			if (push)
				wp_ff <= (wp_ff == PTR_LAST) ? '0 : wp_ff + AW'(1);
			if (pop)
				rp_ff <= (rp_ff == PTR_LAST) ? '0 : rp_ff + AW'(1);
			if (push & ~pop)
				cnt_ff <= cnt_ff + CW'(1);
			else if (pop & ~push)
				cnt_ff <= cnt_ff - CW'(1);
		end
	end
endmodule : uls_fifo
`default_nettype wire

// ### design/uls_fifo_if.sv
// Valid/ready carrier between a FIFO and its users
`timescale 1ns/1ns
`default_nettype none
interface uls_fifo_if #(parameter int W = 8, parameter int DEPTH = 8);
	logic wr_valid;
	logic wr_ready;
	logic [W-1:0] wr_data;
	logic rd_valid;
	logic rd_ready;
	logic [W-1:0] rd_data;
	logic [$clog2(DEPTH+1)-1:0] count;
	modport fifo(input wr_valid, wr_data, rd_ready,
		output wr_ready, rd_valid, rd_data, count);
	modport snk(input rd_valid, rd_data, output rd_ready);
endinterface : uls_fifo_if
`default_nettype wire

// ### design/uls_line_status.sv
// UART receiver, transmitter and line status register
`timescale 1ns/1ns
`default_nettype none
module uls_line_status #(
	parameter int unsigned BAUD_DIV = uls_pkg::BAUD_DIV,
	parameter int unsigned DEPTH = uls_pkg::FIFO_DEPTH
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic SIN,
	output logic SOUT,
	input wire logic FIFO_EN,
	input wire logic [1:0] WORD_LEN,
	input wire logic PARITY_EN,
	input wire logic EVEN_PARITY,
	input wire logic STOP_TWO,
	input wire logic LSR_RD,
	output logic [31:0] LSR_DATA,
	input wire logic RX_RD,
	output logic [7:0] RX_DATA,
	input wire logic TX_WR,
	input wire logic [7:0] TX_DATA,
	output logic TX_READY
);
	localparam int EW = uls_pkg::ENTRY_W;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [15:0] DIV_LAST = 16'(BAUD_DIV - 1);
	localparam logic [CW-1:0] CNT_ONE = CW'(1);

	logic [15:0] div_ff;
	logic tick;
	logic sin_meta_ff;
	logic sin_ff;
	uls_pkg::uls_rx_state_t state_ff;
	logic [3:0] os_ff;
	logic [2:0] bit_ff;
	logic [7:0] data_ff;
	logic zero_ff;
	logic par_bad_ff;
	logic resync_ff;
	logic [2:0] last;
	logic sample;
	logic rx_done;
	logic [EW-1:0] entry;
	logic replace;
	logic push;
	logic pop;
	logic head_new;
	logic head_new_ff;
	logic [CW-1:0] err_cnt_ff;
	logic push_err;
	logic pop_err;
	logic oe_ff;
	logic pe_ff;
	logic fe_ff;
	logic bi_ff;
	logic nxt_oe;
	logic nxt_pe;
	logic nxt_fe;
	logic nxt_bi;
	logic oe_set;
	logic head_chk;
	logic [7:0] lsr_now;
	logic [31:0] lsr_q_ff;
	logic [7:0] rx_data_ff;
	logic tx_busy;
	logic tx_holding_empty_flag;
	logic transmitter_idle_flag;

	uls_fifo_if #(.W(EW), .DEPTH(DEPTH)) rx_f();
	uls_fifo_if #(.W(uls_pkg::DATA_W), .DEPTH(DEPTH)) tx_f();

	uls_fifo #(.W(EW), .DEPTH(DEPTH)) u_rx_fifo (
		.clk(CLK),
		.rst(RST),
		.f(rx_f)
	);

	uls_fifo #(.W(uls_pkg::DATA_W), .DEPTH(DEPTH)) u_tx_fifo (
		.clk(CLK),
		.rst(RST),
		.f(tx_f)
	);

	uls_tx u_tx (
		.clk(CLK),
		.rst(RST),
		.tick(tick),
		.wls(WORD_LEN),
		.pen(PARITY_EN),
		.even_parity_select(EVEN_PARITY),
		.stb(STOP_TWO),
		.q(tx_f),
		.sout(SOUT),
		.busy(tx_busy)
	);

	// Sixteen-times bit rate tick
	assign tick = div_ff == DIV_LAST;
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
			div_ff <= 16'h0000;
		else
			div_ff <= tick ? 16'h0000 : div_ff + 16'h0001;
	end

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			sin_meta_ff <= 1'b1;
			sin_ff <= 1'b1;
		end
		else
		begin
			sin_meta_ff <= SIN;
			sin_ff <= sin_meta_ff;
		end
	end

	// Transmit side; non-FIFO mode holds a single character
	assign TX_READY = tx_f.wr_ready & (FIFO_EN | tx_f.count == '0);
	assign tx_f.wr_valid = TX_WR & TX_READY;
	assign tx_f.wr_data = TX_DATA;
	assign tx_holding_empty_flag = tx_f.count == '0;
	assign transmitter_idle_flag = tx_holding_empty_flag & ~tx_busy;

	// Receiver
	assign last = uls_pkg::uls_last_bit(WORD_LEN);
	assign sample = tick && os_ff == uls_pkg::LAST_TICK;
	assign rx_done = state_ff == uls_pkg::RX_STOP && sample;
	// One stop bit decides framing; break is an all-low character
	assign entry = {zero_ff & ~sin_ff, ~sin_ff,
		par_bad_ff, data_ff};

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			state_ff <= uls_pkg::RX_IDLE;
			os_ff <= 4'h0;
			bit_ff <= 3'h0;
			data_ff <= 8'h00;
			zero_ff <= 1'b0;
			par_bad_ff <= 1'b0;
			resync_ff <= 1'b0;
		end
		else
		begin
			unique case (state_ff)
				uls_pkg::RX_IDLE:
				begin
					os_ff <= 4'h0;
					resync_ff <= 1'b0;
					if (!sin_ff)
						state_ff <= uls_pkg::RX_START;
				end
				uls_pkg::RX_START:
				begin
					if (tick)
					begin
						// Second look at a resync start comes one tick later
						if (os_ff == (resync_ff ? 4'h0 : uls_pkg::MID_TICK))
						begin
							os_ff <= 4'h0;
							data_ff <= 8'h00;
							zero_ff <= 1'b1;
							bit_ff <= 3'h0;
							par_bad_ff <= 1'b0;
							state_ff <= sin_ff ? uls_pkg::RX_IDLE : uls_pkg::RX_DATA;
						end
						else
							os_ff <= os_ff + 4'h1;
					end
				end
				uls_pkg::RX_DATA:
				begin
					if (tick)
						os_ff <= os_ff + 4'h1;
					if (sample)
					begin
						data_ff[bit_ff] <= sin_ff;
						zero_ff <= zero_ff & ~sin_ff;
						bit_ff <= bit_ff + 3'h1;
						if (bit_ff == last)
							state_ff <= PARITY_EN ? uls_pkg::RX_PAR : uls_pkg::RX_STOP;
					end
				end
				uls_pkg::RX_PAR:
				begin
					if (tick)
						os_ff <= os_ff + 4'h1;
					if (sample)
					begin
						par_bad_ff <= ^data_ff ^ sin_ff ^ ~EVEN_PARITY;
						zero_ff <= zero_ff & ~sin_ff;
						state_ff <= uls_pkg::RX_STOP;
					end
				end
				uls_pkg::RX_STOP:
				begin
					if (tick)
						os_ff <= os_ff + 4'h1;
					if (sample)
					begin
						os_ff <= 4'h0;
						resync_ff <= ~sin_ff;
						if (sin_ff)
							state_ff <= uls_pkg::RX_IDLE;
						else if (zero_ff)
							state_ff <= uls_pkg::RX_BRK;
						else
							state_ff <= uls_pkg::RX_START;
					end
				end
				uls_pkg::RX_BRK:
				begin
					if (sin_ff)
						state_ff <= uls_pkg::RX_IDLE;
				end
				default:
					state_ff <= uls_pkg::RX_IDLE;
			endcase
		end
	end

	// Receive buffering and overrun
	assign replace = rx_done & ~FIFO_EN & rx_f.rd_valid;
	assign rx_f.wr_valid = rx_done;
	assign rx_f.wr_data = entry;
	assign rx_f.rd_ready = RX_RD | replace;
	assign oe_set = rx_done & (FIFO_EN ? ~rx_f.wr_ready : rx_f.rd_valid);
	assign push = rx_f.wr_valid & rx_f.wr_ready;
	assign pop = rx_f.rd_valid & rx_f.rd_ready;
	assign push_err = push & (|entry[EW-1:uls_pkg::ENT_PE]);
	assign pop_err = pop & (|rx_f.rd_data[EW-1:uls_pkg::ENT_PE]);
	assign head_new = (push & rx_f.count == '0)
		| (pop & ~push & rx_f.count > CNT_ONE)
		| (pop & push & rx_f.count >= CNT_ONE);
	assign head_chk = head_new_ff & rx_f.rd_valid;

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			err_cnt_ff <= '0;
			head_new_ff <= 1'b0;
			rx_data_ff <= 8'h00;
		end
		else
		begin
			head_new_ff <= head_new;
			if (push_err & ~pop_err)
				err_cnt_ff <= err_cnt_ff + CW'(1);
			else if (pop_err & ~push_err)
				err_cnt_ff <= err_cnt_ff - CW'(1);
			if (RX_RD & rx_f.rd_valid)
				rx_data_ff <= rx_f.rd_data[7:0];
		end
	end

	// Sticky flags: a new event wins over the read that clears
	always_comb
	begin
		nxt_oe = oe_set | (oe_ff & ~LSR_RD);
		nxt_pe = (head_chk & rx_f.rd_data[uls_pkg::ENT_PE])
			| (pe_ff & ~LSR_RD);
		nxt_fe = (head_chk & rx_f.rd_data[uls_pkg::ENT_FE])
			| (fe_ff & ~LSR_RD);
		nxt_bi = (head_chk & rx_f.rd_data[uls_pkg::ENT_BI])
			| (bi_ff & ~LSR_RD);
	end

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			oe_ff <= 1'b0;
			pe_ff <= 1'b0;
			fe_ff <= 1'b0;
			bi_ff <= 1'b0;
		end
		else
		begin
			oe_ff <= nxt_oe;
			pe_ff <= nxt_pe;
			fe_ff <= nxt_fe;
			bi_ff <= nxt_bi;
		end
	end

	always_comb
	begin
		lsr_now = 8'h00;
		lsr_now[uls_pkg::LSR_FERR] = FIFO_EN & (err_cnt_ff != '0);
		lsr_now[uls_pkg::LSR_TRANSMITTER_IDLE_FLAG] = transmitter_idle_flag;
		lsr_now[uls_pkg::LSR_TX_HOLDING_EMPTY_FLAG] = tx_holding_empty_flag;
		lsr_now[uls_pkg::LSR_BI] = bi_ff;
		lsr_now[uls_pkg::LSR_FE] = fe_ff;
		lsr_now[uls_pkg::LSR_PE] = pe_ff;
		lsr_now[uls_pkg::LSR_OE] = oe_ff;
		lsr_now[uls_pkg::LSR_DR] = rx_f.rd_valid;
	end

	// Read-only snapshot; upper bits always zero
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
			lsr_q_ff <= uls_pkg::LSR_RESET;
		else if (LSR_RD)
			lsr_q_ff <= {24'h000000, lsr_now};
	end

	assign LSR_DATA = lsr_q_ff;
	assign RX_DATA = rx_data_ff;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	property p_ferr_set;
		FIFO_EN && push_err |=> lsr_now[uls_pkg::LSR_FERR];
	endproperty
	a_ferr_set: assert property (p_ferr_set) else $error("bit7 not set");
	property p_ferr_hold;
		$fell(err_cnt_ff != '0) |-> $past(pop_err);
	endproperty
	a_ferr_hold: assert property (p_ferr_hold) else $error("bit7 early");
	property p_transmitter_idle_flag;
		transmitter_idle_flag |-> tx_holding_empty_flag && !tx_busy;
	endproperty
	a_transmitter_idle_flag: assert property (p_transmitter_idle_flag) else $error("bit6 wrong");
	property p_tx_holding_empty_flag;
		tx_f.wr_valid |=> !tx_holding_empty_flag;
	endproperty
	a_tx_holding_empty_flag: assert property (p_tx_holding_empty_flag) else $error("bit5 stuck");
	property p_break;
		rx_done && zero_ff && !sin_ff |=> state_ff == uls_pkg::RX_BRK;
	endproperty
	a_break: assert property (p_break) else $error("break missed");
	property p_brk_wait;
		state_ff == uls_pkg::RX_BRK && !sin_ff |=> state_ff == uls_pkg::RX_BRK;
	endproperty
	a_brk_wait: assert property (p_brk_wait) else $error("left break");
	property p_fe_resync;
		rx_done && !sin_ff && !zero_ff |=> state_ff == uls_pkg::RX_START
			&& resync_ff;
	endproperty
	a_fe_resync: assert property (p_fe_resync) else $error("no resync");
	property p_oe_nofifo;
		!FIFO_EN && rx_done && rx_f.rd_valid |=> oe_ff;
	endproperty
	a_oe_nofifo: assert property (p_oe_nofifo) else $error("no overrun");
	property p_oe_fifo;
		FIFO_EN && rx_done && !rx_f.wr_ready |-> !push ##1 oe_ff;
	endproperty
	a_oe_fifo: assert property (p_oe_fifo) else $error("full overrun");
	property p_dr;
		push |=> lsr_now[uls_pkg::LSR_DR];
	endproperty
	a_dr: assert property (p_dr) else $error("no data ready");
	property p_clear;
		LSR_RD && !oe_set ##1 !oe_set |-> !oe_ff;
	endproperty
	a_clear: assert property (p_clear) else $error("oe not cleared");
	property p_upper;
		$rose(LSR_RD) |=> LSR_DATA[31:8] == 24'h000000;
	endproperty
	a_upper: assert property (p_upper) else $error("upper bits set");

	c_break: cover property (state_ff == uls_pkg::RX_BRK);
	c_frame: cover property (rx_done && !sin_ff && !zero_ff);
	c_overrun: cover property (oe_set && FIFO_EN);
	c_full: cover property (!rx_f.wr_ready);
endmodule : uls_line_status
`default_nettype wire

// ### design/uls_pkg.sv
// Constants, types and helpers for the line status block
package uls_pkg;
	localparam int unsigned CLK_HZ = 125_000_000;
	localparam int unsigned BAUD_RATE = 9600;
	localparam int unsigned OVERSAMPLE = 16;
	localparam int unsigned BAUD_DIV = CLK_HZ / (OVERSAMPLE * BAUD_RATE);
	localparam int unsigned FIFO_DEPTH = 8;
	localparam int DATA_W = 8;
	localparam int ENTRY_W = 11;
	localparam int ENT_PE = 8;
	localparam int ENT_FE = 9;
	localparam int ENT_BI = 10;
	localparam int LSR_W = 32;
	localparam int LSR_DR = 0;
	localparam int LSR_OE = 1;
	localparam int LSR_PE = 2;
	localparam int LSR_FE = 3;
	localparam int LSR_BI = 4;
	localparam int LSR_TX_HOLDING_EMPTY_FLAG = 5;
	localparam int LSR_TRANSMITTER_IDLE_FLAG = 6;
	localparam int LSR_FERR = 7;
	localparam logic [31:0] LSR_RESET = 32'h0000_0060;
	localparam logic [3:0] MID_TICK = 4'h7;
	localparam logic [3:0] LAST_TICK = 4'hf;
	localparam logic [2:0] MIN_LAST_BIT = 3'h4;

	typedef enum logic [2:0] {
		RX_IDLE = 3'h0,
		RX_START = 3'h1,
		RX_DATA = 3'h2,
		RX_PAR = 3'h3,
		RX_STOP = 3'h4,
		RX_BRK = 3'h5
	} uls_rx_state_t;

	// Index of the last data bit for a word length code
	function automatic logic [2:0] uls_last_bit(input logic [1:0] wls);
		uls_last_bit = MIN_LAST_BIT + {1'b0, wls};
	endfunction : uls_last_bit
endpackage : uls_pkg

// ### design/uls_tx.sv
// Serial transmitter fed from the transmit FIFO
`timescale 1ns/1ns
`default_nettype none
module uls_tx (
	input wire logic clk,
	input wire logic rst,
	input wire logic tick,
	input wire logic [1:0] wls,
	input wire logic pen,
	input wire logic even_parity_select,
	input wire logic stb,
	uls_fifo_if.snk q,
	output logic sout,
	output logic busy
);
	logic [11:0] frame_ff;
	logic [11:0] nxt_frame;
	logic [3:0] left_ff;
	logic [3:0] os_ff;
	logic [3:0] nxt_left;
	logic [2:0] last;
	logic [7:0] dm;

	assign last = uls_pkg::uls_last_bit(wls);
	assign busy = left_ff != 4'h0;
	assign q.rd_ready = ~busy;
	assign sout = frame_ff[0];

	// Frame image: start, data, optional parity, stop bits (idle ones above)
	always_comb
	begin
		nxt_frame = '1;
		dm = '0;
		nxt_frame[0] = 1'b0;
		for (int i = 0; i < 8; i++)
		begin
			if (3'(i) <= last)
			begin
				dm[i] = q.rd_data[i];
				nxt_frame[i + 1] = q.rd_data[i];
			end
		end
		if (pen)
			nxt_frame[4'(last) + 4'h2] = even_parity_select ? ^dm : ~^dm;
		nxt_left = 4'h2 + 4'(last) + 4'(pen) + (stb ? 4'h2 : 4'h1);
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			frame_ff <= '1;
			left_ff <= 4'h0;
			os_ff <= 4'h0;
		end
		else if (!busy)
		begin
			os_ff <= 4'h0;
			if (q.rd_valid)
			begin
				frame_ff <= nxt_frame;
				left_ff <= nxt_left;
			end
		end
		else if (tick)
		begin
			os_ff <= os_ff + 4'h1;
			if (os_ff == uls_pkg::LAST_TICK)
			begin
				frame_ff <= {1'b1, frame_ff[11:1]};
				left_ff <= left_ff - 4'h1;
			end
		end
	end
endmodule : uls_tx
`default_nettype wire

// ### verification/test_uls_line_status.sv
// Self-checking bench for the line status block
`timescale 1ns/1ns
`default_nettype none
module test_uls_line_status;
	localparam int BD = 2;
	localparam int BIT_CLK = 16 * BD;
	logic clk, rst, sin, sout, fifo_en, par_en, even_par, stop_two;
	logic lsr_rd, rx_rd, tx_wr, tx_ready;
	logic [1:0] word_len;
	logic [31:0] lsr_data;
	logic [7:0] rx_data, tx_data;
	int n_mismatch, checked;

	uls_line_status #(.BAUD_DIV(BD), .DEPTH(8)) uls_line_status_i (
		.CLK(clk), .RST(rst), .SIN(sin), .SOUT(sout), .FIFO_EN(fifo_en),
		.WORD_LEN(word_len), .PARITY_EN(par_en), .EVEN_PARITY(even_par),
		.STOP_TWO(stop_two), .LSR_RD(lsr_rd), .LSR_DATA(lsr_data),
		.RX_RD(rx_rd), .RX_DATA(rx_data), .TX_WR(tx_wr), .TX_DATA(tx_data),
		.TX_READY(tx_ready));

	uls_remote_dev #(.BIT_CLK(BIT_CLK)) uls_remote_dev_i (
		.clk(clk), .sin(sin), .sout(sout));

	always #4 clk = ~clk;

	task automatic give_verdict();
		if (n_mismatch == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic rd_lsr(output logic [31:0] v);
		@(negedge clk);
		lsr_rd = 1'b1;
		@(negedge clk);
		lsr_rd = 1'b0;
		v = lsr_data;
	endtask : rd_lsr

	task automatic pop(output logic [7:0] d);
		@(negedge clk);
		rx_rd = 1'b1;
		@(negedge clk);
		rx_rd = 1'b0;
		d = rx_data;
	endtask : pop

	task automatic wr_tx(input logic [7:0] d);
		int n;
		n = 0;
		while (tx_ready !== 1'b1 && n < 2000)
		begin
			@(negedge clk);
			n++;
		end
		if (n >= 2000)
		begin
			n_mismatch++;
			give_verdict();
		end
		tx_data = d;
		tx_wr = 1'b1;
		@(negedge clk);
		tx_wr = 1'b0;
	endtask : wr_tx

	task automatic send(input logic [7:0] d, input int nb, input logic badp,
		input logic badst);
		uls_remote_dev_i.send_frame(d, nb, par_en, even_par, badp, badst);
	endtask : send

	task automatic t_reset();
		logic [31:0] v;
		chk(lsr_data, 32'h60);
		chk({31'h0, tx_ready}, 32'h1);
		rd_lsr(v);
		chk(v, 32'h60);
	endtask : t_reset

	// Every word length, with two stop bits set but one sent
	task automatic t_words();
		logic [31:0] v;
		logic [7:0] d, m;
		stop_two = 1'b1;
		for (int w = 0; w < 4; w++)
		begin
			word_len = w[1:0];
			m = 8'hb5 & (8'hff >> (3 - w));
			send(m, 5 + w, 1'b0, 1'b0);
			rd_lsr(v);
			chk(v, 32'h61);
			pop(d);
			chk({24'h0, d}, {24'h0, m});
			rd_lsr(v);
			chk(v, 32'h60);
		end
		stop_two = 1'b0;
		word_len = 2'h3;
	endtask : t_words

	task automatic t_parity();
		logic [31:0] v;
		logic [7:0] d;
		par_en = 1'b1;
		for (int e = 0; e < 2; e++)
			for (int b = 0; b < 2; b++)
			begin
				even_par = e[0];
				send(8'h3c, 8, b[0], 1'b0);
				rd_lsr(v);
				chk(v, b[0] ? 32'h65 : 32'h61);
				rd_lsr(v);
				chk(v, 32'h61);
				pop(d);
				chk({24'h0, d}, 32'h3c);
			end
		par_en = 1'b0;
	endtask : t_parity

	// The low stop bit must start the next character, read as all ones
	task automatic t_framing();
		logic [31:0] v;
		logic [7:0] d;
		send(8'ha5, 8, 1'b0, 1'b1);
		rd_lsr(v);
		chk(v, 32'h69);
		pop(d);
		chk({24'h0, d}, 32'ha5);
		repeat (11 * BIT_CLK) @(negedge clk);
		rd_lsr(v);
		chk(v, 32'h61);
		pop(d);
		chk({24'h0, d}, 32'hff);
	endtask : t_framing

	// A long break must give one character only, then normal reception
	task automatic t_break();
		logic [31:0] v;
		logic [7:0] d;
		uls_remote_dev_i.send_break(20);
		rd_lsr(v);
		chk(v, 32'h79);
		pop(d);
		chk({24'h0, d}, 32'h0);
		send(8'h5a, 8, 1'b0, 1'b0);
		rd_lsr(v);
		chk(v, 32'h61);
		pop(d);
		chk({24'h0, d}, 32'h5a);
	endtask : t_break

	task automatic t_overrun();
		logic [31:0] v;
		logic [7:0] d;
		send(8'h11, 8, 1'b0, 1'b0);
		send(8'h22, 8, 1'b0, 1'b0);
		rd_lsr(v);
		chk(v, 32'h63);
		pop(d);
		chk({24'h0, d}, 32'h22);
		rd_lsr(v);
		chk(v, 32'h60);
	endtask : t_overrun

	task automatic t_tx();
		logic [31:0] v;
		logic [7:0] d;
		logic ok;
		wr_tx(8'hc3);
		wr_tx(8'h3c);
		rd_lsr(v);
		chk({30'h0, v[6:5]}, 32'h0);
		uls_remote_dev_i.get_frame(8, d, ok);
		chk({23'h0, ok, d}, 32'h1c3);
		uls_remote_dev_i.get_frame(8, d, ok);
		chk({23'h0, ok, d}, 32'h13c);
		repeat (BIT_CLK) @(negedge clk);
		rd_lsr(v);
		chk(v, 32'h60);
		chk({31'h0, tx_ready}, 32'h1);
	endtask : t_tx

	// Two bad characters among nine; the ninth finds the buffer full
	task automatic t_fifo();
		logic [7:0] ch [9] = '{8'h81, 8'h10, 8'h42, 8'h20, 8'h21, 8'h22,
			8'h23, 8'h24, 8'h25};
		logic [31:0] ex [3] = '{32'he1, 32'he5, 32'h61};
		logic [31:0] v;
		logic [7:0] d;
		fifo_en = 1'b1;
		par_en = 1'b1;
		even_par = 1'b1;
		for (int i = 0; i < 9; i++)
			send(ch[i], 8, i == 0 || i == 2, 1'b0);
		rd_lsr(v);
		chk(v, 32'he7);
		for (int i = 0; i < 8; i++)
		begin
			pop(d);
			chk({24'h0, d}, {24'h0, ch[i]});
			if (i < 3)
			begin
				rd_lsr(v);
				chk(v, ex[i]);
			end
		end
		rd_lsr(v);
		chk(v, 32'h60);
	endtask : t_fifo

	initial
	begin
		clk = 1'b0;
		rst = 1'b1;
		fifo_en = 1'b0;
		word_len = 2'h3;
		par_en = 1'b0;
		even_par = 1'b0;
		stop_two = 1'b0;
		lsr_rd = 1'b0;
		rx_rd = 1'b0;
		tx_wr = 1'b0;
		tx_data = 8'h00;
		n_mismatch = 0;
		checked = 0;
		repeat (6) @(negedge clk);
		rst = 1'b0;
		repeat (2) @(negedge clk);
		t_reset();
		t_words();
		t_parity();
		t_framing();
		t_break();
		t_overrun();
		t_tx();
		t_fifo();
		give_verdict();
	end
endmodule : test_uls_line_status
`default_nettype wire

// ### verification/uls_remote_dev.sv
// Remote serial device that drives the receive line and watches the send line
`timescale 1ns/1ns
`default_nettype none
module uls_remote_dev #(parameter int BIT_CLK = 32) (
	input wire logic clk,
	output logic sin,
	input wire logic sout
);
	initial sin = 1'b1;

	// Callers enter at a falling edge, so the line changes off the sampling edge
	task automatic hold(input logic v, input int nb);
		sin = v;
		repeat (nb * BIT_CLK) @(negedge clk);
	endtask : hold

	task automatic send_frame(input logic [7:0] d, input int nb,
		input logic pen, input logic even, input logic badp, input logic badst);
		logic p;
		p = even ? ^d : ~^d;
		hold(1'b0, 1);
		for (int i = 0; i < nb; i++)
			hold(d[i], 1);
		if (pen)
			hold(p ^ badp, 1);
		hold(~badst, 1);
		hold(1'b1, 0);
	endtask : send_frame

	task automatic send_break(input int nb);
		hold(1'b0, nb);
		hold(1'b1, 1);
	endtask : send_break

	// Samples each bit near its middle; ok is low on a missing start or stop
	task automatic get_frame(input int nb, output logic [7:0] d,
		output logic ok);
		int n;
		n = 0;
		d = 8'h00;
		while (sout !== 1'b0 && n < 400)
		begin
			@(negedge clk);
			n++;
		end
		repeat (BIT_CLK / 2) @(negedge clk);
		ok = (n < 400) && (sout === 1'b0);
		for (int i = 0; i < nb; i++)
		begin
			repeat (BIT_CLK) @(negedge clk);
			d[i] = sout;
		end
		repeat (BIT_CLK) @(negedge clk);
		ok = ok && (sout === 1'b1);
	endtask : get_frame
endmodule : uls_remote_dev
`default_nettype wire
